// ---- verilog/flow_cmd_pkg.sv ----
package flow_cmd_pkg;
  localparam logic [7:0]  FRAME_HDR   = 8'h9d;
  localparam logic [7:0]  FRAME_END   = 8'h0d;
  localparam logic [7:0]  CMD_SET_CF  = 8'h03;
  localparam logic [7:0]  CMD_CAL     = 8'h72;
  localparam logic [7:0]  CMD_RESTORE = 8'h78;
  localparam logic [7:0]  CMD_RD_TIME = 8'h82;
  localparam logic [7:0]  CMD_RD_CF   = 8'h83;
  localparam logic [7:0]  KEY_BYTE    = 8'h55;
  localparam logic [7:0]  MAX_LEN     = 8'h66;
  localparam logic [7:0]  LEN0        = 8'h00;
  localparam logic [7:0]  LEN1        = 8'h01;
  localparam logic [7:0]  LEN2        = 8'h02;
  localparam logic [7:0]  STATUS_OK   = 8'h01;
  localparam logic [7:0]  STATUS_FAIL = 8'h00;
  localparam logic [15:0] TIME_DEFAULT = 16'h000a;
  localparam logic [15:0] CF_DEFAULT  = 16'h03e8;
  localparam logic [15:0] OFF_DEFAULT = 16'h0000;
  localparam logic        LINE_IDLE   = 1'b1;
  localparam logic        START_BIT   = 1'b0;
  localparam logic        STOP_BIT    = 1'b1;
  localparam logic        FLAG_HDR    = 1'b1;
  localparam logic        FLAG_DATA   = 1'b0;
  localparam int          FLAG_POS    = 8;
  localparam logic [3:0]  START_IDX   = 4'h0;
  localparam logic [3:0]  STOP_IDX    = 4'ha;
  localparam logic [2:0]  IDX_HDR     = 3'h0;
  localparam logic [2:0]  IDX_CMD     = 3'h1;
  localparam logic [2:0]  IDX_LEN     = 3'h2;
  localparam logic [2:0]  IDX_DATA    = 3'h3;
  localparam logic [2:0]  FRAME_OVERHEAD = 3'h5;
  localparam int          CLK_HZ      = 25_000_000;
  localparam int          BAUD_BPS    = 38_400;
  localparam int          BIT_CYC     = CLK_HZ / BAUD_BPS;
  localparam int          TIMEOUT_S   = 1;
  localparam int          TIMEOUT_CYC = CLK_HZ * TIMEOUT_S;

  typedef enum logic [3:0] {D_HDR, D_CMD, D_LEN, D_DATA, D_CSUM, D_END, D_EXEC, D_CAL, D_TX} dev_state_t;
  typedef enum logic [2:0] {P_HDR, P_CMD, P_LEN, P_DATA, P_CSUM, P_END} parse_state_t;

  // Byte idx of a frame carrying at most two data bytes; the checksum XORs command, length and data.
  function automatic logic [7:0] frame_byte(input logic [2:0] idx, input logic [7:0] cmd, input logic [7:0] len,
                                            input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] cs;
    cs = cmd ^ len ^ ((len != LEN0) ? d0 : LEN0) ^ ((len == LEN2) ? d1 : LEN0);
    if (idx == IDX_HDR) frame_byte = FRAME_HDR;
    else if (idx == IDX_CMD) frame_byte = cmd;
    else if (idx == IDX_LEN) frame_byte = len;
    else if (idx < IDX_DATA + len[2:0]) frame_byte = (idx == IDX_DATA) ? d0 : d1;
    else if (idx == IDX_DATA + len[2:0]) frame_byte = cs;
    else frame_byte = FRAME_END;
  endfunction : frame_byte

  function automatic logic [7:0] status_of(input logic ok);
    status_of = ok ? STATUS_OK : STATUS_FAIL;
  endfunction : status_of
endpackage : flow_cmd_pkg

// ---- verilog/flow_link_if.sv ----
`timescale 1ns/1ps
// Two one-way lines, each idling high; the half-duplex wire is modelled as a line per direction.
interface flow_link_if;
  logic m2s;
  logic s2m;
  modport device (input m2s, output s2m);
  modport host   (output m2s, input s2m);
endinterface : flow_link_if

// ---- verilog/flow_cmd_device.sv ----
`timescale 1ns/1ps
// How it works
// R1: Command 03 with two bytes sets factor.
// R2: Factor is high byte times 256 plus low.
// R3: Set-factor reply 03, length 1, status byte.
// R4: Command 72 with key 55 starts calibration.
// R5: Calibration reply 72, length 2, signed offset.
// R6: Command 78 with key 55 restores defaults.
// R7: Defaults: 10 ms, factor 1000, default offset.
// R8: Restore reply 78, length 1, status byte.
// R9: Command 82 reads response time, two bytes.
// R10: Response time is high times 256 plus low.
// R11: Command 83 reads factor, two bytes back.
// R12: Frames: header 9D, XOR checksum, end 0D.
// R13: Bytes are 11 bits; device flag always 0.
// R14: Length above 102 gets no reply.
// R15: One second without bytes abandons frame.
// R16: Act only after checksum and end verified.
module flow_cmd_device
  import flow_cmd_pkg::*;
#(
  parameter int          BIT_CYCLES     = BIT_CYC,
  parameter int          TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter logic [15:0] OFFSET_DEFAULT = OFF_DEFAULT
) (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        CE_I,
  flow_link_if.device      LINK,
  input  wire logic        CAL_DONE_I,
  input  wire logic [15:0] CAL_OFFSET_I,
  output logic             CAL_START_O,
  output logic [15:0]      RESP_TIME_O,
  output logic [15:0]      CORR_FACTOR_O,
  output logic [15:0]      ZERO_OFFSET_O
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  logic [2:0]    sync_q;
  logic          line_q;
  logic          rx_busy_q;
  logic [CW-1:0] rx_cnt_q;
  logic [3:0]    rx_bit_q;
  logic [9:0]    rx_sh_q;
  logic          rx_stb_q;
  dev_state_t    state_q;
  logic [7:0]    cmd_q;
  logic [7:0]    len_q;
  logic [7:0]    d0_q;
  logic [7:0]    d1_q;
  logic [7:0]    xor_q;
  logic [6:0]    cnt_q;
  logic [TW-1:0] tmo_q;
  logic [15:0]   resp_time_ms_q;
  logic [15:0]   gas_correction_factor_q;
  logic [15:0]   zero_offset_q;
  logic [7:0]    rsp_cmd_q;
  logic [7:0]    rsp_len_q;
  logic [7:0]    rsp_hi_q;
  logic [7:0]    rsp_lo_q;
  logic          cal_start_q;
  logic [2:0]    tx_idx_q;
  logic [10:0]   tx_sh_q;
  logic [3:0]    tx_bit_q;
  logic [CW-1:0] tx_cnt_q;
  logic          tx_act_q;

  wire       rx_tick   = rx_busy_q && (rx_cnt_q == '0);
  wire [7:0] rx_byte   = rx_sh_q[7:0];
  wire       rx_flag   = rx_sh_q[FLAG_POS];
  wire       receiving = (state_q != D_EXEC) && (state_q != D_CAL) && (state_q != D_TX);
  wire       in_frame  = receiving && (state_q != D_HDR);
  // R12: header resync
  wire       hdr_seen  = rx_stb_q && rx_flag && (rx_byte == FRAME_HDR);
  // R15: inactivity expiry
  wire       tmo       = in_frame && (tmo_q == TW'(TIMEOUT_CYCLES - 1));
  wire       key_ok    = (len_q == LEN1) && (d0_q == KEY_BYTE);
  wire       cf_ok     = (len_q == LEN2);
  wire [2:0] tx_total  = FRAME_OVERHEAD + rsp_len_q[2:0];
  wire       tx_go     = (state_q == D_TX) && !tx_act_q && (tx_idx_q != tx_total);
  wire       tx_done   = (state_q == D_TX) && !tx_act_q && (tx_idx_q == tx_total);
  wire       last_data = (cnt_q + 7'h01) == len_q[6:0];
  // Only the second and third stages are compared, so a single-cycle glitch never reaches the receiver.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync_q <= {3{LINE_IDLE}};
      line_q <= LINE_IDLE;
    end else if (CE_I) begin
      sync_q <= {sync_q[1:0], LINK.m2s};
      if (sync_q[1] == sync_q[2]) line_q <= sync_q[2];
    end
  end
  // R13: 11-bit receive
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= '0;
      rx_bit_q  <= START_IDX;
      rx_sh_q   <= '0;
      rx_stb_q  <= 1'b0;
    end else if (CE_I) begin
      rx_stb_q <= rx_tick && (rx_bit_q == STOP_IDX) && (line_q == STOP_BIT);
      if (!rx_busy_q) begin
        if (line_q == START_BIT) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= CW'(BIT_CYCLES / 2);
          rx_bit_q  <= START_IDX;
        end
      end else if (!rx_tick) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= CW'(BIT_CYCLES - 1);
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == START_IDX) rx_busy_q <= (line_q == START_BIT);
        else rx_sh_q <= {line_q, rx_sh_q[9:1]};
        if (rx_bit_q == STOP_IDX) rx_busy_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) tmo_q <= '0;
    else if (CE_I) begin
      // R15: timer restart
      if (rx_stb_q || !in_frame) tmo_q <= '0;
      else tmo_q <= tmo_q + 1'b1;
    end
  end
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q                 <= D_HDR;
      cmd_q                   <= '0;
      len_q                   <= '0;
      d0_q                    <= '0;
      d1_q                    <= '0;
      xor_q                   <= '0;
      cnt_q                   <= '0;
      resp_time_ms_q          <= TIME_DEFAULT;
      gas_correction_factor_q <= CF_DEFAULT;
      zero_offset_q           <= OFFSET_DEFAULT;
      rsp_cmd_q               <= '0;
      rsp_len_q               <= '0;
      rsp_hi_q                <= '0;
      rsp_lo_q                <= '0;
      cal_start_q             <= 1'b0;
    end else if (CE_I) begin
      cal_start_q <= 1'b0;
      if (receiving && hdr_seen) begin
        state_q <= D_CMD;
      end else if (tmo) begin
        state_q <= D_HDR;
      end else begin
        unique case (state_q)
          D_HDR: begin
          end
          D_CMD: if (rx_stb_q) begin
            cmd_q   <= rx_byte;
            xor_q   <= rx_byte;
            state_q <= D_LEN;
          end
          D_LEN: if (rx_stb_q) begin
            len_q <= rx_byte;
            xor_q <= xor_q ^ rx_byte;
            cnt_q <= '0;
            // R14: oversize length dropped
            if (rx_byte > MAX_LEN) state_q <= D_HDR;
            else if (rx_byte == LEN0) state_q <= D_CSUM;
            else state_q <= D_DATA;
          end
          D_DATA: if (rx_stb_q) begin
            if (cnt_q == 7'h00) d0_q <= rx_byte;
            if (cnt_q == 7'h01) d1_q <= rx_byte;
            xor_q <= xor_q ^ rx_byte;
            cnt_q <= cnt_q + 7'h01;
            if (last_data) state_q <= D_CSUM;
          end
          // R16: verify before acting
          D_CSUM: if (rx_stb_q) state_q <= (rx_byte == xor_q) ? D_END : D_HDR;
          D_END: if (rx_stb_q) state_q <= (rx_byte == FRAME_END) ? D_EXEC : D_HDR;
          D_EXEC: begin
            rsp_cmd_q <= cmd_q;
            rsp_len_q <= LEN1;
            state_q   <= D_TX;
            case (cmd_q)
              CMD_SET_CF: begin
                // R1: store new factor
                // R2: high byte first
                if (cf_ok) gas_correction_factor_q <= {d0_q, d1_q};
                // R3: status reply
                rsp_hi_q <= status_of(cf_ok);
              end
              CMD_CAL: begin
                // R4: keyed calibration start
                if (key_ok) begin
                  cal_start_q <= 1'b1;
                  state_q     <= D_CAL;
                end else state_q <= D_HDR;
              end
              CMD_RESTORE: begin
                // R6: keyed restore
                // R7: default values
                if (key_ok) begin
                  resp_time_ms_q          <= TIME_DEFAULT;
                  gas_correction_factor_q <= CF_DEFAULT;
                  zero_offset_q           <= OFFSET_DEFAULT;
                end
                // R8: status reply
                rsp_hi_q <= status_of(key_ok);
              end
              CMD_RD_TIME: begin
                // R9: read response time
                // R10: high byte first
                rsp_len_q            <= LEN2;
                {rsp_hi_q, rsp_lo_q} <= resp_time_ms_q;
                if (len_q != LEN0) state_q <= D_HDR;
              end
              CMD_RD_CF: begin
                // R11: read factor
                rsp_len_q            <= LEN2;
                {rsp_hi_q, rsp_lo_q} <= gas_correction_factor_q;
                if (len_q != LEN0) state_q <= D_HDR;
              end
              default: state_q <= D_HDR;
            endcase
          end
          D_CAL: if (CAL_DONE_I) begin
            // R5: offset reply
            zero_offset_q        <= CAL_OFFSET_I;
            rsp_len_q            <= LEN2;
            {rsp_hi_q, rsp_lo_q} <= CAL_OFFSET_I;
            state_q              <= D_TX;
          end
          D_TX: if (tx_done) state_q <= D_HDR;
        endcase
      end
    end
  end
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_idx_q <= IDX_HDR;
      tx_sh_q  <= {11{LINE_IDLE}};
      tx_bit_q <= START_IDX;
      tx_cnt_q <= '0;
      tx_act_q <= 1'b0;
    end else if (CE_I) begin
      if (state_q != D_TX) tx_idx_q <= IDX_HDR;
      if (tx_go) begin
        // R13: device flag zero
        // R12: framed reply
        tx_sh_q  <= {STOP_BIT, FLAG_DATA,
                     frame_byte(tx_idx_q, rsp_cmd_q, rsp_len_q, rsp_hi_q, rsp_lo_q), START_BIT};
        tx_act_q <= 1'b1;
        tx_bit_q <= START_IDX;
        tx_cnt_q <= CW'(BIT_CYCLES - 1);
      end else if (tx_act_q) begin
        if (tx_cnt_q != '0) tx_cnt_q <= tx_cnt_q - 1'b1;
        else begin
          tx_cnt_q <= CW'(BIT_CYCLES - 1);
          tx_sh_q  <= {LINE_IDLE, tx_sh_q[10:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == STOP_IDX) begin
            tx_act_q <= 1'b0;
            tx_idx_q <= tx_idx_q + 3'h1;
          end
        end
      end
    end
  end
  assign LINK.s2m      = tx_sh_q[0];
  assign CAL_START_O   = cal_start_q;
  assign RESP_TIME_O   = resp_time_ms_q;
  assign CORR_FACTOR_O = gas_correction_factor_q;
  assign ZERO_OFFSET_O = zero_offset_q;
endmodule : flow_cmd_device

// ---- verilog/flow_cmd_host.sv ----
`timescale 1ns/1ps
module flow_cmd_host
  import flow_cmd_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
) (
  input  wire logic       CLK_I,
  input  wire logic       RSTN_I,
  input  wire logic       CE_I,
  flow_link_if.host       LINK,
  input  wire logic       SEND_I,
  input  wire logic [7:0] CMD_I,
  input  wire logic [1:0] LEN_I,
  input  wire logic [7:0] DATA0_I,
  input  wire logic [7:0] DATA1_I,
  output logic            BUSY_O,
  output logic            RSP_VALID_O,
  output logic [7:0]      RSP_CMD_O,
  output logic [7:0]      RSP_LEN_O,
  output logic [7:0]      RSP_DATA0_O,
  output logic [7:0]      RSP_DATA1_O
);
  localparam int CW = $clog2(BIT_CYCLES + 1);

  logic [2:0]    sync_q;
  logic          line_q;
  logic          rx_busy_q;
  logic [CW-1:0] rx_cnt_q;
  logic [3:0]    rx_bit_q;
  logic [9:0]    rx_sh_q;
  logic          rx_stb_q;
  parse_state_t  ps_q;
  logic [7:0]    xor_q;
  logic [6:0]    cnt_q;
  logic [7:0]    rcmd_q;
  logic [7:0]    rlen_q;
  logic [7:0]    rd0_q;
  logic [7:0]    rd1_q;
  logic          valid_q;
  logic          busy_q;
  logic [7:0]    cmd_q;
  logic [7:0]    len_q;
  logic [7:0]    d0_q;
  logic [7:0]    d1_q;
  logic [2:0]    tx_idx_q;
  logic [10:0]   tx_sh_q;
  logic [3:0]    tx_bit_q;
  logic [CW-1:0] tx_cnt_q;
  logic          tx_act_q;

  wire       rx_tick  = rx_busy_q && (rx_cnt_q == '0);
  wire [7:0] rx_byte  = rx_sh_q[7:0];
  wire [2:0] tx_total = FRAME_OVERHEAD + len_q[2:0];
  wire       tx_go    = busy_q && !tx_act_q && (tx_idx_q != tx_total);
  wire       start    = SEND_I && !busy_q;
  // The header alone carries the flag set, so the device can find frame starts.
  // R13: header flag set
  wire       tx_flag  = (tx_idx_q == IDX_HDR) ? FLAG_HDR : FLAG_DATA;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync_q <= {3{LINE_IDLE}};
      line_q <= LINE_IDLE;
    end else if (CE_I) begin
      sync_q <= {sync_q[1:0], LINK.s2m};
      if (sync_q[1] == sync_q[2]) line_q <= sync_q[2];
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= '0;
      rx_bit_q  <= START_IDX;
      rx_sh_q   <= '0;
      rx_stb_q  <= 1'b0;
    end else if (CE_I) begin
      rx_stb_q <= rx_tick && (rx_bit_q == STOP_IDX) && (line_q == STOP_BIT);
      if (!rx_busy_q) begin
        if (line_q == START_BIT) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= CW'(BIT_CYCLES / 2);
          rx_bit_q  <= START_IDX;
        end
      end else if (!rx_tick) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= CW'(BIT_CYCLES - 1);
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == START_IDX) rx_busy_q <= (line_q == START_BIT);
        else rx_sh_q <= {line_q, rx_sh_q[9:1]};
        if (rx_bit_q == STOP_IDX) rx_busy_q <= 1'b0;
      end
    end
  end

  // A reply frame that fails its checksum or end byte is dropped without a valid pulse.
  // R12: reply frame check
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ps_q    <= P_HDR;
      xor_q   <= '0;
      cnt_q   <= '0;
      rcmd_q  <= '0;
      rlen_q  <= '0;
      rd0_q   <= '0;
      rd1_q   <= '0;
      valid_q <= 1'b0;
    end else if (CE_I) begin
      valid_q <= 1'b0;
      if (start) ps_q <= P_HDR;
      else if (rx_stb_q) begin
        unique case (ps_q)
          P_HDR: if (rx_byte == FRAME_HDR) ps_q <= P_CMD;
          P_CMD: begin
            rcmd_q <= rx_byte;
            xor_q  <= rx_byte;
            ps_q   <= P_LEN;
          end
          P_LEN: begin
            rlen_q <= rx_byte;
            xor_q  <= xor_q ^ rx_byte;
            cnt_q  <= '0;
            if (rx_byte > MAX_LEN) ps_q <= P_HDR;
            else ps_q <= (rx_byte == LEN0) ? P_CSUM : P_DATA;
          end
          P_DATA: begin
            if (cnt_q == 7'h00) rd0_q <= rx_byte;
            if (cnt_q == 7'h01) rd1_q <= rx_byte;
            xor_q <= xor_q ^ rx_byte;
            cnt_q <= cnt_q + 7'h01;
            if ((cnt_q + 7'h01) == rlen_q[6:0]) ps_q <= P_CSUM;
          end
          P_CSUM: ps_q <= (rx_byte == xor_q) ? P_END : P_HDR;
          P_END: begin
            valid_q <= (rx_byte == FRAME_END);
            ps_q    <= P_HDR;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      busy_q   <= 1'b0;
      cmd_q    <= '0;
      len_q    <= '0;
      d0_q     <= '0;
      d1_q     <= '0;
      tx_idx_q <= IDX_HDR;
      tx_sh_q  <= {11{LINE_IDLE}};
      tx_bit_q <= START_IDX;
      tx_cnt_q <= '0;
      tx_act_q <= 1'b0;
    end else if (CE_I) begin
      if (start) begin
        busy_q   <= 1'b1;
        cmd_q    <= CMD_I;
        len_q    <= 8'(LEN_I);
        d0_q     <= DATA0_I;
        d1_q     <= DATA1_I;
        tx_idx_q <= IDX_HDR;
      end else if (busy_q && !tx_act_q && (tx_idx_q == tx_total)) begin
        busy_q <= 1'b0;
      end
      if (tx_go) begin
        tx_sh_q  <= {STOP_BIT, tx_flag, frame_byte(tx_idx_q, cmd_q, len_q, d0_q, d1_q), START_BIT};
        tx_act_q <= 1'b1;
        tx_bit_q <= START_IDX;
        tx_cnt_q <= CW'(BIT_CYCLES - 1);
      end else if (tx_act_q) begin
        if (tx_cnt_q != '0) tx_cnt_q <= tx_cnt_q - 1'b1;
        else begin
          tx_cnt_q <= CW'(BIT_CYCLES - 1);
          tx_sh_q  <= {LINE_IDLE, tx_sh_q[10:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == STOP_IDX) begin
            tx_act_q <= 1'b0;
            tx_idx_q <= tx_idx_q + 3'h1;
          end
        end
      end
    end
  end

  assign LINK.m2s    = tx_sh_q[0];
  assign BUSY_O      = busy_q;
  assign RSP_VALID_O = valid_q;
  assign RSP_CMD_O   = rcmd_q;
  assign RSP_LEN_O   = rlen_q;
  assign RSP_DATA0_O = rd0_q;
  assign RSP_DATA1_O = rd1_q;
endmodule : flow_cmd_host

// ---- tb/flow_link_assertions.sv ----
`timescale 1ns/1ps
module flow_link_assertions
  import flow_cmd_pkg::*;
#(
  parameter int BIT_CYCLES = 8
) (
  input wire logic        CLK_I,
  input wire logic        RSTN_I,
  input wire logic        m2s,
  input wire logic        s2m,
  input wire logic        SEND_I,
  input wire logic        BUSY_O,
  input wire logic        RSP_VALID_O,
  input wire logic        CAL_START_O,
  input wire logic        CAL_DONE_I,
  input wire logic [15:0] CAL_OFFSET_I,
  input wire logic [15:0] CORR_FACTOR_O,
  input wire logic [15:0] ZERO_OFFSET_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Bit times are fixed at eight cycles in the bench, so no low run is ever shorter.
  chk_host_bit_width: assert property ($fell(m2s) |-> (!m2s) [*8])
    else $error("host line low run too short");
  chk_dev_bit_width: assert property ($fell(s2m) |-> (!s2m) [*8])
    else $error("device line low run too short");
  chk_host_idle_high: assert property (!BUSY_O |-> m2s)
    else $error("host line not idle while free");
  chk_send_takes_busy: assert property (SEND_I && !BUSY_O |=> BUSY_O)
    else $error("send request not taken");
  chk_frame_start_bit: assert property ($rose(BUSY_O) |-> ##[0:2] !m2s)
    else $error("frame did not start");
  chk_cal_start_pulse: assert property (CAL_START_O |=> !CAL_START_O)
    else $error("calibration start longer than one cycle");
  chk_cal_offset_kept: assert property ($rose(CAL_DONE_I) |-> ##[1:3] (ZERO_OFFSET_O == CAL_OFFSET_I))
    else $error("calibrated offset not stored");
  chk_cal_reply_starts: assert property ($rose(CAL_DONE_I) |-> ##[1:5] !s2m)
    else $error("calibration reply late");
  chk_factor_then_reply: assert property ($changed(CORR_FACTOR_O) |-> ##[1:6] !s2m)
    else $error("factor changed without a reply");
  chk_rsp_one_pulse: assert property (RSP_VALID_O |=> !RSP_VALID_O)
    else $error("reply valid longer than one cycle");
  cover property (RSP_VALID_O);
  cover property ($rose(CAL_DONE_I));
  cover property ($changed(CORR_FACTOR_O));
endmodule : flow_link_assertions

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import flow_cmd_pkg::*;
  localparam int BITC = 8;
  logic        clk     = 1'b0;
  logic        rstn    = 1'b0;
  logic        ce      = 1'b1;
  logic        send    = 1'b0;
  logic        cal_done = 1'b0;
  logic [7:0]  cmd     = 8'h00;
  logic [1:0]  len     = 2'h0;
  logic [7:0]  d0      = 8'h00;
  logic [7:0]  d1      = 8'h00;
  logic [15:0] cal_off = 16'hfe0c;
  logic        busy, rsp_valid, cal_start;
  logic [7:0]  rcmd, rlen, rd0, rd1;
  logic [15:0] resp_time, cf, off, cf2;
  int          failures = 0;
  int          compares = 0;
  flow_link_if link ();
  flow_link_if link2 ();
  always #20 clk = ~clk;
  // Calibration completes half a cycle after it is started.
  always @(negedge clk) cal_done <= cal_start;
  flow_cmd_device #(.BIT_CYCLES(BITC), .TIMEOUT_CYCLES(2000)) i_flow_cmd_device (.CLK_I(clk), .RSTN_I(rstn),
    .CE_I(ce), .LINK(link.device), .CAL_DONE_I(cal_done), .CAL_OFFSET_I(cal_off), .CAL_START_O(cal_start),
    .RESP_TIME_O(resp_time), .CORR_FACTOR_O(cf), .ZERO_OFFSET_O(off));
  flow_cmd_host #(.BIT_CYCLES(BITC)) i_flow_cmd_host (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .LINK(link.host),
    .SEND_I(send), .CMD_I(cmd), .LEN_I(len), .DATA0_I(d0), .DATA1_I(d1), .BUSY_O(busy), .RSP_VALID_O(rsp_valid),
    .RSP_CMD_O(rcmd), .RSP_LEN_O(rlen), .RSP_DATA0_O(rd0), .RSP_DATA1_O(rd1));
  // This end faces the bench's own byte driver so that broken frames can be sent.
  flow_cmd_device #(.BIT_CYCLES(BITC), .TIMEOUT_CYCLES(2000)) i_flow_cmd_device_raw (.CLK_I(clk), .RSTN_I(rstn),
    .CE_I(ce), .LINK(link2.device), .CAL_DONE_I(1'b0), .CAL_OFFSET_I(16'h0000), .CAL_START_O(),
    .RESP_TIME_O(), .CORR_FACTOR_O(cf2), .ZERO_OFFSET_O());
  flow_link_assertions #(.BIT_CYCLES(BITC)) i_flow_link_assertions (.CLK_I(clk), .RSTN_I(rstn), .m2s(link.m2s),
    .s2m(link.s2m), .SEND_I(send), .BUSY_O(busy), .RSP_VALID_O(rsp_valid), .CAL_START_O(cal_start),
    .CAL_DONE_I(cal_done), .CAL_OFFSET_I(cal_off), .CORR_FACTOR_O(cf), .ZERO_OFFSET_O(off));

  task print_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task xact(input logic [7:0] c, input logic [1:0] l, input logic [7:0] a, b, ec, el, e0, e1);
    int n;
    @(negedge clk);
    cmd = c;
    len = l;
    d0 = a;
    d1 = b;
    send = 1'b1;
    @(negedge clk);
    send = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 3000) begin
      failures++;
      print_verdict();
    end
    check({rcmd, rlen}, {ec, el});
    check({rd0, (el == LEN2) ? rd1 : 8'h00}, {e0, e1});
  endtask : xact

  task raw_frame(input logic [7:0] b[7], input int n);
    logic [10:0] w;
    @(negedge clk);
    for (int k = 0; k < n; k++) begin
      w = {STOP_BIT, (k == 0 && b[k] == FRAME_HDR), b[k], START_BIT};
      for (int i = 0; i < 11; i++) begin
        link2.m2s = w[i];
        repeat (BITC) @(negedge clk);
      end
    end
  endtask : raw_frame

  task quiet(input int cyc);
    logic [15:0] lows;
    lows = 16'h0000;
    repeat (cyc) begin
      @(negedge clk);
      if (link2.s2m !== LINE_IDLE) lows++;
    end
    check(lows, 16'h0000);
  endtask : quiet

  task rx_check(input logic [7:0] exp[6]);
    logic [10:0] w;
    int n;
    for (int k = 0; k < 6; k++) begin
      n = 0;
      while (link2.s2m !== START_BIT && n < 3000) begin
        @(negedge clk);
        n++;
      end
      if (n == 3000) begin
        failures++;
        print_verdict();
      end
      repeat (BITC / 2) @(negedge clk);
      for (int i = 0; i < 11; i++) begin
        w[i] = link2.s2m;
        if (i < 10) repeat (BITC) @(negedge clk);
      end
      check({5'h00, w}, {5'h00, STOP_BIT, FLAG_DATA, exp[k], START_BIT});
    end
  endtask : rx_check

  initial begin
    link2.m2s = LINE_IDLE;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    check(cf, 16'h03e8);
    // Both ends freeze together, so a pause in mid-frame must leave the transfer intact.
    fork
      xact(8'h83, 2'h0, 8'h00, 8'h00, 8'h83, 8'h02, 8'h03, 8'he8);
      begin
        repeat (200) @(negedge clk);
        ce = 1'b0;
        repeat (50) @(negedge clk);
        ce = 1'b1;
      end
    join
    xact(8'h03, 2'h2, 8'h12, 8'h34, 8'h03, 8'h01, 8'h01, 8'h00);
    check(cf, 16'h1234);
    xact(8'h83, 2'h0, 8'h00, 8'h00, 8'h83, 8'h02, 8'h12, 8'h34);
    xact(8'h82, 2'h0, 8'h00, 8'h00, 8'h82, 8'h02, 8'h00, 8'h0a);
    xact(8'h03, 2'h1, 8'h56, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00);
    check(cf, 16'h1234);
    xact(8'h72, 2'h1, 8'h55, 8'h00, 8'h72, 8'h02, 8'hfe, 8'h0c);
    check(off, 16'hfe0c);
    xact(8'h78, 2'h1, 8'h54, 8'h00, 8'h78, 8'h01, 8'h00, 8'h00);
    check(cf, 16'h1234);
    xact(8'h78, 2'h1, 8'h55, 8'h00, 8'h78, 8'h01, 8'h01, 8'h00);
    check(cf, 16'h03e8);
    check(off, 16'h0000);
    check(resp_time, 16'h000a);
    raw_frame('{8'h9d, 8'h03, 8'h02, 8'h11, 8'h22, 8'h33, 8'h0d}, 7);
    quiet(300);
    raw_frame('{8'h9d, 8'h83, 8'h67, 8'he4, 8'h0d, 8'h00, 8'h00}, 5);
    quiet(300);
    raw_frame('{8'h9d, 8'h03, 8'h02, 8'h11, 8'h00, 8'h00, 8'h00}, 4);
    repeat (2100) @(negedge clk);
    raw_frame('{8'h22, 8'h32, 8'h0d, 8'h00, 8'h00, 8'h00, 8'h00}, 3);
    quiet(300);
    check(cf2, 16'h03e8);
    raw_frame('{8'h9d, 8'h03, 8'h02, 8'h11, 8'h22, 8'h32, 8'h0d}, 7);
    rx_check('{8'h9d, 8'h03, 8'h01, 8'h01, 8'h03, 8'h0d});
    check(cf2, 16'h1122);
    print_verdict();
  end
endmodule : tb_top
